// ==== logic/steer_monitor_pkg.sv ====
package steer_monitor_pkg;

  localparam int unsigned CNT_W           = 32;
  localparam longint      CLK_FREQ_HZ     = 200_000_000;
  localparam longint      PERSIST_TIME_MS = 60;
  localparam longint      HOLD_TIME_MS    = 100;

  // rounded down, both figures are exact at this rate
  localparam logic [CNT_W-1:0] PERSIST_CYCLES = CNT_W'(CLK_FREQ_HZ / 1000 * PERSIST_TIME_MS);
  localparam logic [CNT_W-1:0] HOLD_CYCLES    = CNT_W'(CLK_FREQ_HZ / 1000 * HOLD_TIME_MS);

  localparam int unsigned      ACTION_W        = 4;
  localparam logic [ACTION_W-1:0] TRACTION_NONE = 4'h0;
  localparam logic [ACTION_W-1:0] TRACTION_STOP = 4'h1;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b001,
    ST_HOLD     = 3'b010,
    ST_SHUTDOWN = 3'b100
  } steer_state_type;

endpackage : steer_monitor_pkg

// ==== logic/pair_check_if.sv ====
`timescale 1ns/100ps
interface pair_check_if #(parameter int W = 12);
  logic         enable;
  logic         sawtooth_mode;
  logic         sample_valid;
  logic [W-1:0] channel_a;
  logic [W-1:0] channel_b;
  logic [W-1:0] gain;
  logic [W-1:0] offset;
  logic [W-1:0] fault_volts;
  logic [W-1:0] upper_sweep_voltage;
  logic [W-1:0] lower_sweep_voltage;
  logic [W-1:0] tolerance;
  logic         sincos_event;
  logic         sawtooth_event;

  modport monitor (
    output enable, sawtooth_mode, sample_valid, channel_a, channel_b, gain, offset,
           fault_volts, upper_sweep_voltage, lower_sweep_voltage, tolerance,
    input  sincos_event, sawtooth_event
  );
  modport evaluator (
    input  enable, sawtooth_mode, sample_valid, channel_a, channel_b, gain, offset,
           fault_volts, upper_sweep_voltage, lower_sweep_voltage, tolerance,
    output sincos_event, sawtooth_event
  );
endinterface : pair_check_if

// ==== logic/pair_checker.sv ====
`timescale 1ns/100ps
module pair_checker #(
  parameter int                               W       = 12,
  parameter logic [steer_monitor_pkg::CNT_W-1:0] PERSIST = steer_monitor_pkg::PERSIST_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_n,
  pair_check_if.evaluator chk
);
  import steer_monitor_pkg::*;

  logic [W-1:0]       diff;
  logic [W:0]         sweep_sum;
  logic [W:0]         diff_dbl;
  logic [W:0]         dev_dbl;
  logic               over_tol;
  logic signed [W:0]  xa;
  logic signed [W:0]  xb;
  logic [2*W+2:0]     radius_sq;
  logic [W-1:0]       low_r;
  logic [W:0]         high_r;
  logic [2*W-1:0]     low_sq;
  logic [2*W+1:0]     high_sq;
  logic               mismatch;
  logic               dev_d, dev_q;
  logic [CNT_W-1:0]   cnt_d, cnt_q;

  always_comb begin
    // doubled on both sides so the half-sum stays exact
    diff      = (chk.channel_a >= chk.channel_b) ? chk.channel_a - chk.channel_b
                                                 : chk.channel_b - chk.channel_a;
    sweep_sum = {1'b0, chk.upper_sweep_voltage} + {1'b0, chk.lower_sweep_voltage};
    diff_dbl  = {diff, 1'b0};
    dev_dbl   = (diff_dbl >= sweep_sum) ? diff_dbl - sweep_sum : sweep_sum - diff_dbl;
    over_tol  = dev_dbl > {chk.tolerance, 1'b0};
    // ring check on squares avoids a square root
    xa        = $signed({1'b0, chk.channel_a}) - $signed({1'b0, chk.offset});
    xb        = $signed({1'b0, chk.channel_b}) - $signed({1'b0, chk.offset});
    // squares formed at full width, a self-sized product would wrap
    radius_sq = (2*W+3)'(xa * xa) + (2*W+3)'(xb * xb);
    low_r     = (chk.gain > chk.fault_volts) ? chk.gain - chk.fault_volts : '0;
    high_r    = {1'b0, chk.gain} + {1'b0, chk.fault_volts};
    low_sq    = low_r * low_r;
    high_sq   = high_r * high_r;
    mismatch  = (radius_sq < {3'b000, low_sq}) || (radius_sq > {1'b0, high_sq});
  end

  always_comb begin
    dev_d = dev_q;
    if (!chk.enable || !chk.sawtooth_mode) begin
      dev_d = 1'b0;
    end else if (chk.sample_valid) begin
      dev_d = over_tol;
    end
    // back within tolerance restarts the wait
    cnt_d = '0;
    if (dev_q && dev_d) begin
      cnt_d = (cnt_q == PERSIST - 1'b1) ? cnt_q : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      dev_q <= dev_d;
      cnt_q <= cnt_d;
    end
  end

  assign chk.sincos_event   = chk.enable && !chk.sawtooth_mode && chk.sample_valid && mismatch;
  // gated so a count ending as the keyswitch drops cannot relatch
  assign chk.sawtooth_event = chk.enable && dev_q && (cnt_q == PERSIST - 1'b1);

endmodule : pair_checker

// ==== logic/steer_sensor_plausibility_monitor.sv ====
// Behaviour
// - sine/cosine command pair off the ideal ring by over fault volts flags fault
// - same sine/cosine check on the feedback pair flags a feedback fault
// - sawtooth command deviation is abs(abs(a-b) - half sweep sum) against tolerance
// - same sawtooth deviation on the feedback pair against feedback tolerance
// - sawtooth fault set only after deviation persists continuously for 60 ms
// - any fault holds steering, then shuts down; latched until keyswitch cycles
// - while any fault is active traction action code 1, stop, is reported
`timescale 1ns/100ps
module steer_sensor_plausibility_monitor
  import steer_monitor_pkg::*;
#(
  parameter int                 W       = 12,
  parameter logic [CNT_W-1:0]   PERSIST = steer_monitor_pkg::PERSIST_CYCLES,
  parameter logic [CNT_W-1:0]   HOLD    = steer_monitor_pkg::HOLD_CYCLES
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 keyswitch_input,
  input  wire logic                                 command_is_sawtooth,
  input  wire logic                                 command_sample_valid,
  input  wire logic [W-1:0]                         command_channel_a,
  input  wire logic [W-1:0]                         command_channel_b,
  input  wire logic [W-1:0]                         command_gain,
  input  wire logic [W-1:0]                         command_offset,
  input  wire logic [W-1:0]                         command_fault_volts,
  input  wire logic [W-1:0]                         command_upper_sweep_voltage,
  input  wire logic [W-1:0]                         command_lower_sweep_voltage,
  input  wire logic [W-1:0]                         command_tolerance,
  input  wire logic                                 feedback_is_sawtooth,
  input  wire logic                                 feedback_sample_valid,
  input  wire logic [W-1:0]                         feedback_channel_a,
  input  wire logic [W-1:0]                         feedback_channel_b,
  input  wire logic [W-1:0]                         feedback_gain,
  input  wire logic [W-1:0]                         feedback_offset,
  input  wire logic [W-1:0]                         feedback_fault_volts,
  input  wire logic [W-1:0]                         feedback_upper_sweep_voltage,
  input  wire logic [W-1:0]                         feedback_lower_sweep_voltage,
  input  wire logic [W-1:0]                         feedback_tolerance,
  output logic                                      command_sincos_fault,
  output logic                                      command_sawtooth_fault,
  output logic                                      feedback_sincos_fault,
  output logic                                      feedback_sawtooth_fault,
  output logic                                      steer_hold,
  output logic                                      steer_shutdown,
  output logic [steer_monitor_pkg::ACTION_W-1:0]    traction_fault_action
);
  import steer_monitor_pkg::*;

  logic              ks_meta_q, ks_sync_q;
  logic              ks_on;
  logic [3:0]        flags_d, flags_q;
  logic [3:0]        events;
  logic              any_fault_d;
  steer_state_type   state_d, state_q;
  logic [CNT_W-1:0]  hold_cnt_d, hold_cnt_q;
  logic              hold_d, hold_q;
  logic              shut_d, shut_q;
  logic [ACTION_W-1:0] action_d, action_q;

  pair_check_if #(.W(W)) cmd_if ();
  pair_check_if #(.W(W)) fb_if ();

  // keyswitch is a pin: two stages before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ks_meta_q <= 1'b0;
      ks_sync_q <= 1'b0;
    end else begin
      ks_meta_q <= keyswitch_input;
      ks_sync_q <= ks_meta_q;
    end
  end
  assign ks_on = ks_sync_q;

  assign cmd_if.enable              = ks_on;
  assign cmd_if.sawtooth_mode       = command_is_sawtooth;
  assign cmd_if.sample_valid        = command_sample_valid;
  assign cmd_if.channel_a           = command_channel_a;
  assign cmd_if.channel_b           = command_channel_b;
  assign cmd_if.gain                = command_gain;
  assign cmd_if.offset              = command_offset;
  assign cmd_if.fault_volts         = command_fault_volts;
  assign cmd_if.upper_sweep_voltage = command_upper_sweep_voltage;
  assign cmd_if.lower_sweep_voltage = command_lower_sweep_voltage;
  assign cmd_if.tolerance           = command_tolerance;

  assign fb_if.enable              = ks_on;
  assign fb_if.sawtooth_mode       = feedback_is_sawtooth;
  assign fb_if.sample_valid        = feedback_sample_valid;
  assign fb_if.channel_a           = feedback_channel_a;
  assign fb_if.channel_b           = feedback_channel_b;
  assign fb_if.gain                = feedback_gain;
  assign fb_if.offset              = feedback_offset;
  assign fb_if.fault_volts         = feedback_fault_volts;
  assign fb_if.upper_sweep_voltage = feedback_upper_sweep_voltage;
  assign fb_if.lower_sweep_voltage = feedback_lower_sweep_voltage;
  assign fb_if.tolerance           = feedback_tolerance;

  pair_checker #(.W(W), .PERSIST(PERSIST)) u_command (
    .clk   (clk),
    .rst_n (rst_n),
    .chk   (cmd_if.evaluator)
  );

  pair_checker #(.W(W), .PERSIST(PERSIST)) u_feedback (
    .clk   (clk),
    .rst_n (rst_n),
    .chk   (fb_if.evaluator)
  );

  assign events = {fb_if.sawtooth_event, fb_if.sincos_event,
                   cmd_if.sawtooth_event, cmd_if.sincos_event};

  always_comb begin
    // keyswitch off clears; events are gated by the same ks_on, so none can set in that cycle
    flags_d = (ks_on ? flags_q : 4'h0) | events;
    any_fault_d = |flags_d;
    state_d    = state_q;
    hold_cnt_d = '0;
    case (state_q)
      ST_RUN: begin
        if (any_fault_d) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        hold_cnt_d = hold_cnt_q + 1'b1;
        if (!any_fault_d) begin
          state_d = ST_RUN;
        end else if (hold_cnt_q == HOLD - 1'b1) begin
          state_d = ST_SHUTDOWN;
        end
      end
      ST_SHUTDOWN: begin
        // only a keyswitch cycle releases the drive
        if (!any_fault_d) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    hold_d   = (state_d == ST_HOLD);
    shut_d   = (state_d == ST_SHUTDOWN);
    action_d = any_fault_d ? TRACTION_STOP : TRACTION_NONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q    <= 4'h0;
      state_q    <= ST_RUN;
      hold_cnt_q <= '0;
      hold_q     <= 1'b0;
      shut_q     <= 1'b0;
      action_q   <= TRACTION_NONE;
    end else begin
      flags_q    <= flags_d;
      state_q    <= state_d;
      hold_cnt_q <= hold_cnt_d;
      hold_q     <= hold_d;
      shut_q     <= shut_d;
      action_q   <= action_d;
    end
  end

  assign command_sincos_fault    = flags_q[0];
  assign command_sawtooth_fault  = flags_q[1];
  assign feedback_sincos_fault   = flags_q[2];
  assign feedback_sawtooth_fault = flags_q[3];
  assign steer_hold              = hold_q;
  assign steer_shutdown          = shut_q;
  assign traction_fault_action   = action_q;

endmodule : steer_sensor_plausibility_monitor

// ==== verif/steer_monitor_properties.sv ====
`timescale 1ns/100ps
module steer_monitor_properties #(
  parameter int PERSIST = 20,
  parameter int HOLD    = 10
) (
  input wire logic                                clk,
  input wire logic                                rst_n,
  input wire logic                                keyswitch_input,
  input wire logic                                command_is_sawtooth,
  input wire logic                                command_sample_valid,
  input wire logic                                feedback_is_sawtooth,
  input wire logic                                feedback_sample_valid,
  input wire logic                                command_sincos_fault,
  input wire logic                                command_sawtooth_fault,
  input wire logic                                feedback_sincos_fault,
  input wire logic                                feedback_sawtooth_fault,
  input wire logic                                steer_hold,
  input wire logic                                steer_shutdown,
  input wire logic [steer_monitor_pkg::ACTION_W-1:0] traction_fault_action
);
  wire any_fault = command_sincos_fault | command_sawtooth_fault | feedback_sincos_fault
                   | feedback_sawtooth_fault;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // four samples cover the two-flop keyswitch synchroniser plus the clearing edge
  sequence ks_held; keyswitch_input [*4]; endsequence
  sequence ks_dropped; !keyswitch_input [*4]; endsequence
  chk_action_code: assert property (traction_fault_action == (any_fault ? 4'h1 : 4'h0))
    else $error("traction action does not track fault flags");
  chk_hold_entry: assert property ($rose(any_fault) |-> steer_hold && !steer_shutdown)
    else $error("new fault did not enter hold");
  chk_hold_length: assert property ($rose(steer_shutdown) |->
    $past(steer_hold, HOLD) && !$past(steer_hold, HOLD + 1)) else $error("hold length wrong");
  chk_fault_latch: assert property (ks_held ##0 any_fault |=> any_fault)
    else $error("fault dropped with keyswitch on");
  chk_keyswitch_clear: assert property (ks_dropped |-> !any_fault && !steer_hold
    && !steer_shutdown) else $error("outputs not cleared by keyswitch off");
  chk_cmd_sincos: assert property ($rose(command_sincos_fault) |->
    $past(command_sample_valid) && !$past(command_is_sawtooth)) else $error("cmd sincos cause");
  chk_fb_sincos: assert property ($rose(feedback_sincos_fault) |->
    $past(feedback_sample_valid) && !$past(feedback_is_sawtooth)) else $error("fb sincos cause");
  chk_cmd_persist: assert property ($rose(command_sawtooth_fault) |->
    $past(command_is_sawtooth) && $past(keyswitch_input, PERSIST)) else $error("cmd saw early");
  chk_fb_persist: assert property ($rose(feedback_sawtooth_fault) |->
    $past(feedback_is_sawtooth) && $past(keyswitch_input, PERSIST)) else $error("fb saw early");
endmodule : steer_monitor_properties
bind steer_sensor_plausibility_monitor steer_monitor_properties #(.PERSIST(PERSIST), .HOLD(HOLD))
  steer_monitor_properties_inst (.clk(clk), .rst_n(rst_n), .keyswitch_input(keyswitch_input),
  .command_is_sawtooth(command_is_sawtooth), .command_sample_valid(command_sample_valid),
  .feedback_is_sawtooth(feedback_is_sawtooth), .feedback_sample_valid(feedback_sample_valid),
  .command_sincos_fault(command_sincos_fault), .command_sawtooth_fault(command_sawtooth_fault),
  .feedback_sincos_fault(feedback_sincos_fault), .steer_hold(steer_hold),
  .feedback_sawtooth_fault(feedback_sawtooth_fault), .steer_shutdown(steer_shutdown),
  .traction_fault_action(traction_fault_action));

// ==== verif/sensor_pair_model.sv ====
`timescale 1ns/100ps
module sensor_pair_model (
  input  wire logic        clk,
  input  wire logic [11:0] a_set,
  input  wire logic [11:0] b_set,
  input  wire logic [3:0]  gap,
  output logic             valid,
  output logic [11:0]      a,
  output logic [11:0]      b
);
  logic [3:0] cnt = 4'h0;
  initial valid = 1'b0;
  initial a = 12'h000;
  initial b = 12'h000;
  // gap 0 is silent, 1 every cycle, larger a slow sensor
  always @(negedge clk) begin
    if (gap != 4'h0 && cnt + 4'h1 >= gap) begin
      valid <= 1'b1;
      a <= a_set;
      b <= b_set;
      cnt <= 4'h0;
    end else begin
      // samples mean nothing between valids, so idle lines keep toggling
      valid <= 1'b0;
      a <= ~a;
      b <= ~b;
      cnt <= cnt + 4'h1;
    end
  end
endmodule : sensor_pair_model

// ==== verif/steer_sensor_plausibility_monitor_tb.sv ====
`timescale 1ns/100ps
module steer_sensor_plausibility_monitor_tb;
  import steer_monitor_pkg::*;
  localparam int P = 20;
  localparam int H = 10;
  logic clk = 1'b0, rst_n = 1'b0, keyswitch_input = 1'b1, c_saw = 1'b0, f_saw = 1'b0;
  logic [11:0] c_a = 12'h000, c_b = 12'h000, f_a = 12'h000, f_b = 12'h000;
  logic [3:0] c_g = 4'h0, f_g = 4'h0;
  logic [11:0] gn = 12'h3E8, ofs = 12'h800, fv = 12'h032;
  logic [11:0] up = 12'hBB8, lo = 12'h3E8, tol = 12'h064;
  logic c_v, f_v, c_sc, c_st, f_sc, f_st, hold, shut;
  logic [11:0] ca, cb, fa, fb;
  logic [ACTION_W-1:0] act;
  wire [3:0] flags = {f_st, f_sc, c_st, c_sc};
  int bad_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  sensor_pair_model cmd_model_inst (.clk(clk), .a_set(c_a), .b_set(c_b), .gap(c_g),
    .valid(c_v), .a(ca), .b(cb));
  sensor_pair_model fb_model_inst (.clk(clk), .a_set(f_a), .b_set(f_b), .gap(f_g),
    .valid(f_v), .a(fa), .b(fb));
  steer_sensor_plausibility_monitor #(.W(12), .PERSIST(P), .HOLD(H))
    steer_sensor_plausibility_monitor_inst (.clk(clk), .rst_n(rst_n),
    .keyswitch_input(keyswitch_input), .command_is_sawtooth(c_saw), .command_sample_valid(c_v),
    .command_channel_a(ca), .command_channel_b(cb), .command_gain(gn),
    .command_offset(ofs), .command_fault_volts(fv),
    .command_upper_sweep_voltage(up), .command_lower_sweep_voltage(lo),
    .command_tolerance(tol), .feedback_is_sawtooth(f_saw), .feedback_sample_valid(f_v),
    .feedback_channel_a(fa), .feedback_channel_b(fb), .feedback_gain(gn),
    .feedback_offset(ofs), .feedback_fault_volts(fv),
    .feedback_upper_sweep_voltage(up), .feedback_lower_sweep_voltage(lo),
    .feedback_tolerance(tol), .command_sincos_fault(c_sc), .command_sawtooth_fault(c_st),
    .feedback_sincos_fault(f_sc), .feedback_sawtooth_fault(f_st), .steer_hold(hold),
    .steer_shutdown(shut), .traction_fault_action(act));
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_code(input logic [ACTION_W-1:0] got, input logic [ACTION_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t action %h want %h", $time, got, exp);
    end
  endtask : chk_code
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks
  task automatic wait_flag(input int i);
    int k;
    k = 0;
    while (flags[i] !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    if (k == 40) begin
      bad_count++;
      $display("[FAIL] %0t wait expired", $time);
      conclude();
    end
  endtask : wait_flag
  task automatic put(input logic side, input logic [11:0] a, input logic [11:0] b,
                     input logic [3:0] g);
    if (side) {f_a, f_b, f_g} = {a, b, g};
    else {c_a, c_b, c_g} = {a, b, g};
  endtask : put
  task automatic key_cycle();
    {c_g, f_g, keyswitch_input} = 9'h000;
    ticks(5);
    chk_bit(hold | shut | (|flags), 1'b0);
    chk_code(act, 4'h0);
    {keyswitch_input, c_saw, f_saw} = 3'b100;
    ticks(3);
  endtask : key_cycle
  task automatic sincos_case(input logic side);
    put(side, 12'h800, 12'hBE8, 4'h1);
    ticks(6);
    chk_bit(flags[2*side], 1'b0);
    put(side, 12'h800, 12'h800, 4'h1);
    wait_flag(2 * side);
    chk_bit(hold & ~shut, 1'b1);
    chk_code(act, 4'h1);
    ticks(H - 1);
    chk_bit(hold & ~shut, 1'b1);
    ticks(1);
    chk_bit(shut & ~hold, 1'b1);
    put(side, 12'h800, 12'hBE8, 4'h1);
    ticks(4);
    chk_bit(flags[2*side], 1'b1);
    key_cycle();
  endtask : sincos_case
  task automatic saw_case(input logic side);
    {f_saw, c_saw} = side ? 2'b10 : 2'b01;
    put(side, 12'hC1C, 12'h3E8, 4'h1);
    ticks(P + 5);
    chk_bit(flags[2*side+1], 1'b0);
    put(side, 12'hBB8, 12'h1F4, 4'h1);
    ticks(P - 2);
    chk_bit(flags[2*side+1], 1'b0);
    wait_flag(2 * side + 1);
    chk_code(act, 4'h1);
    key_cycle();
  endtask : saw_case
  task automatic restart_case();
    c_saw = 1'b1;
    put(1'b0, 12'hBB8, 12'h1F4, 4'h2);
    ticks(P - 4);
    put(1'b0, 12'hBB8, 12'h3E8, 4'h2);
    ticks(4);
    put(1'b0, 12'hBB8, 12'h1F4, 4'h2);
    ticks(P - 2);
    chk_bit(c_st, 1'b0);
    wait_flag(1);
    key_cycle();
  endtask : restart_case
  task automatic param_case();
    c_saw = 1'b1;
    tol = 12'h1F4;
    put(1'b0, 12'hBB8, 12'h1F4, 4'h1);
    ticks(P + 5);
    chk_bit(c_st, 1'b0);
    key_cycle();
    tol = 12'h064;
    gn = 12'h1F4;
    put(1'b0, 12'h800, 12'hBE8, 4'h1);
    wait_flag(0);
    chk_code(act, 4'h1);
    key_cycle();
    gn = 12'h3E8;
  endtask : param_case
  task automatic gate_case();
    c_saw = 1'b1;
    put(1'b0, 12'hBB8, 12'h3E8, 4'h1);
    keyswitch_input = 1'b0;
    put(1'b1, 12'h800, 12'h800, 4'h1);
    ticks(P + 5);
    f_g = 4'h0;
    keyswitch_input = 1'b1;
    ticks(P + 5);
    chk_bit(|flags, 1'b0);
  endtask : gate_case
  initial begin
    ticks(2);
    rst_n = 1'b1;
    ticks(3);
    sincos_case(1'b0);
    sincos_case(1'b1);
    saw_case(1'b0);
    saw_case(1'b1);
    restart_case();
    param_case();
    gate_case();
    conclude();
  end
endmodule : steer_sensor_plausibility_monitor_tb
